// ===== gated_frequency_counter_bench.sv
/*
 * self-checking bench: both link ends joined by gfc_bus_if.
 * assumes NUM_CARRIES 1 and QUIET_CYC 200 to keep runs short.
 */
`timescale 1ns/1ps
`default_nettype none
module gated_frequency_counter_bench;
	import gfc_pkg::*;
	typedef struct {gfc_src_t key; int psel;} gfc_row_t;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        start_i = 1'b0;
	logic        amp_sig = 1'b0;
	logic        in_sig = 1'b0;
	logic        osc_sig = 1'b0;
	logic        volt_mode = 1'b0;
	logic        conv_done = 1'b0;
	gfc_src_t    key = GFC_SRC_OSC;
	logic        busy_o;
	logic        done_o;
	logic        timeout_o;
	logic        gate_open_o;
	logic        counting_o;
	logic [15:0] clk_carries_o;
	logic [15:0] cyc_carries_o;
	logic [15:0] counts_o;
	int          miscompares = 0;
	int          total_checks = 0;
	int          ph = 0;
	gfc_row_t    rows[3] = '{'{GFC_SRC_AMP, 200}, '{GFC_SRC_INPUT, 120}, '{GFC_SRC_OSC, 160}};
	gfc_bus_if bus();
	gfc_device i_gfc_device (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus),
		.amp_sig_i(amp_sig), .in_sig_i(in_sig), .osc_sig_i(osc_sig),
		.special_function_key_i(key), .volt_mode_i(volt_mode), .conv_done_i(conv_done),
		.gate_open_o(gate_open_o), .counting_o(counting_o));
	gfc_controller #(.NUM_CARRIES(1), .QUIET_CYC(200)) i_gfc_controller (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus(bus), .start_i(start_i),
		.busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o),
		.clk_carries_o(clk_carries_o), .cyc_carries_o(cyc_carries_o), .counts_o(counts_o));
	gfc_properties i_gfc_properties (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.sel_stb(bus.sel_stb), .sel_code(bus.sel_code), .rb_data(bus.rb_data),
		.clk_carry_n(bus.clk_carry_n), .clk_carry_oe(bus.clk_carry_oe),
		.cyc_carry_n(bus.cyc_carry_n), .cyc_carry_oe(bus.cyc_carry_oe));
	always #12.5 ref_clk_i = ~ref_clk_i;
	// three unrelated periods, so a wrong source shows in the ratio
	always @(posedge ref_clk_i)
	begin
		#2;
		ph = ph + 1;
		amp_sig = (ph % 200) < 100;
		in_sig = (ph % 120) < 60;
		osc_sig = (ph % 160) < 80;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic pulse_start;
		@(posedge ref_clk_i);
		#2 start_i = 1'b1;
		@(posedge ref_clk_i);
		#2 start_i = 1'b0;
	endtask
	task automatic run_row(input gfc_row_t r);
		int i;
		int ncar;
		int tk;
		int cy;
		int df;
		ncar = 0;
		key = r.key;
		pulse_start();
		for (i = 0; i < 2000 && gate_open_o !== 1'b1; i++)
		begin
			@(posedge ref_clk_i);
			#2;
		end
		chk(gate_open_o, 1'b1);
		if (gate_open_o !== 1'b1)
			final_report();
		chk(counting_o, 1'b1);
		// start while busy must be ignored
		pulse_start();
		for (i = 0; i < 60000 && done_o !== 1'b1; i++)
		begin
			@(posedge ref_clk_i);
			#2;
			if (bus.clock_carry_line_n === 1'b0)
				ncar++;
		end
		if (done_o !== 1'b1)
		begin
			miscompares++;
			final_report();
		end
		#2;
		chk(gate_open_o, 1'b0);
		chk(timeout_o, 1'b0);
		chk(busy_o, 1'b0);
		chk(clk_carries_o, 16'h0001);
		chk(ncar, 1);
		tk = 2048 * clk_carries_o + counts_o[10:0];
		cy = 32 * cyc_carries_o + counts_o[15:11];
		df = tk * 20 - cy * r.psel;
		chk(df >= -60 && df <= 60, 1'b1);
		chk(cy > 100, 1'b1);
		repeat (20) @(posedge ref_clk_i);
		#2;
		chk(bus.clock_carry_line_n, 1'b1);
	endtask
	// voltage mode, then a reset after conv_done while still busy
	task automatic volt_case;
		int i;
		volt_mode = 1'b1;
		pulse_start();
		for (i = 0; i < 200 && counting_o !== 1'b1; i++)
		begin
			@(posedge ref_clk_i);
			#2;
		end
		chk(counting_o, 1'b1);
		chk(gate_open_o, 1'b0);
		// long enough for a cycle carry if the cycle counter ran
		repeat (6000) @(posedge ref_clk_i);
		#2;
		chk(cyc_carries_o, 16'h0000);
		chk(busy_o, 1'b1);
		conv_done = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#2;
		chk(counting_o, 1'b0);
		rst_n_i = 1'b0;
		#2;
		chk(busy_o, 1'b0);
		chk(bus.clock_carry_line_n, 1'b1);
		chk(bus.rb_data, 4'h0);
		repeat (3) @(posedge ref_clk_i);
		#2 rst_n_i = 1'b1;
		volt_mode = 1'b0;
		conv_done = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#2;
		chk(gate_open_o, 1'b0);
		chk(counting_o, 1'b0);
		chk(done_o, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		chk(gate_open_o, 1'b0);
		chk(bus.rb_data, 4'h0);
		chk(bus.clock_carry_line_n, 1'b1);
		#2 rst_n_i = 1'b1;
		foreach (rows[k])
			run_row(rows[k]);
		volt_case();
		final_report();
	end
endmodule // gated_frequency_counter_bench
`default_nettype wire

// ===== gfc_bus_if.sv
/*
 * instrument bus link between controller and counter device.
 * assumes both ends share ref_clk_i; carry lines are wired-or, active low.
 */
`timescale 1ns/1ps
`default_nettype none
interface gfc_bus_if;
	import gfc_pkg::*;
	logic              sel_stb;
	logic [CODE_W-1:0] sel_code;
	logic [RB_W-1:0]   rb_data;
	logic              clk_carry_n;
	logic              clk_carry_oe;
	logic              cyc_carry_n;
	logic              cyc_carry_oe;
	logic              clock_carry_line_n;
	logic              cycle_carry_line_n;

	// pull-up when nobody drives
	assign clock_carry_line_n = clk_carry_oe ? clk_carry_n : 1'b1;
	assign cycle_carry_line_n = cyc_carry_oe ? cyc_carry_n : 1'b1;

	modport dev (
		input  sel_stb, sel_code,
		output rb_data, clk_carry_n, clk_carry_oe, cyc_carry_n, cyc_carry_oe
	);
	modport ctl (
		output sel_stb, sel_code,
		input  rb_data, clock_carry_line_n, cycle_carry_line_n
	);
endinterface
`default_nettype wire

// ===== gfc_controller.sv
/*
 * controller end: issues arm/open/close codes, counts carries as the
 * final counter stages, applies the stopped-signal timeout, reads back.
 * assumes the device shares ref_clk_i, so carry lines need no synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module gfc_controller #(
	parameter int NUM_CARRIES = 977,
	parameter int QUIET_CYC   = 2 * gfc_pkg::CARRY_PERIOD_CYC
) (
	// clock and reset
	input  wire logic                     ref_clk_i,
	input  wire logic                     rst_n_i,
	// instrument bus
	gfc_bus_if.ctl                        bus,
	// user side
	input  wire logic                     start_i,
	output logic                          busy_o,
	output logic                          done_o,
	output logic                          timeout_o,
	output logic [15:0]                   clk_carries_o,
	output logic [15:0]                   cyc_carries_o,
	output logic [gfc_pkg::CNT_W-1:0]     counts_o
);
	import gfc_pkg::*;

	typedef enum logic [2:0] {
		C_IDLE  = 3'h0,
		C_OPEN  = 3'h1,
		C_COUNT = 3'h2,
		C_CLOSE = 3'h3,
		C_WAIT  = 3'h4,
		C_READ  = 3'h5
	} gfc_cstate_t;

	function automatic logic [CODE_W-1:0] rb_code(input logic [1:0] idx);
		unique case (idx)
			2'h0:    rb_code = CMD_RB_SH1;
			2'h1:    rb_code = CMD_RB_SH2;
			default: rb_code = CMD_RB_SH3;
		endcase
	endfunction

	gfc_cstate_t       st_q, st_d;
	logic              stb_q, stb_d;
	logic [CODE_W-1:0] code_q, code_d;
	logic [15:0]       ccar_q, ccar_d;
	logic [15:0]       ycar_q, ycar_d;
	logic [4:0]        after_q, after_d;
	logic [31:0]       quiet_q, quiet_d;
	logic [1:0]        idx_q, idx_d;
	logic [CNT_W-1:0]  acc_q, acc_d;
	logic              done_q, done_d;
	logic              to_q, to_d;
	logic              busy_q, busy_d;

	always_comb
	begin
		st_d    = st_q;
		stb_d   = 1'b0;
		code_d  = code_q;
		ccar_d  = ccar_q;
		ycar_d  = ycar_q;
		after_d = after_q;
		quiet_d = quiet_q + 32'h1;
		idx_d   = idx_q;
		acc_d   = acc_q;
		done_d  = done_q;
		to_d    = to_q;
		if (!bus.cycle_carry_line_n)
			ycar_d = ycar_q + 16'h1;
		if (!bus.clock_carry_line_n)
		begin
			ccar_d  = ccar_q + 16'h1;
			quiet_d = '0;
		end
		unique case (st_q)
			C_IDLE:
				if (start_i)
				begin
					stb_d  = 1'b1;
					code_d = CMD_ARM;
					ccar_d = '0;
					ycar_d = '0;
					done_d = 1'b0;
					to_d   = 1'b0;
					st_d   = C_OPEN;
				end
			C_OPEN:
			begin
				stb_d  = 1'b1;
				code_d = CMD_OPEN;
				st_d   = C_COUNT;
			end
			C_COUNT:
				if (ccar_q >= 16'(NUM_CARRIES))
				begin
					stb_d   = 1'b1;
					code_d  = CMD_CLOSE;
					after_d = '0;
					quiet_d = '0;
					st_d    = C_CLOSE;
				end
			C_CLOSE:
			begin
				if (!bus.clock_carry_line_n)
					after_d = after_q + 5'h1;
				// gate presumed shut once carries stop for a while
				if (after_q >= 5'(CLOSE_TIMEOUT_CARRIES) || quiet_q >= 32'(QUIET_CYC))
				begin
					to_d   = after_q >= 5'(CLOSE_TIMEOUT_CARRIES);
					stb_d  = 1'b1;
					code_d = CMD_RB_EN;
					idx_d  = '0;
					st_d   = C_WAIT;
				end
			end
			C_WAIT:
				st_d = C_READ;
			C_READ:
			begin
				acc_d = {bus.rb_data, acc_q[CNT_W-1:RB_W]};
				if (idx_q == 2'(RB_STAGES - 1))
				begin
					done_d = 1'b1;
					st_d   = C_IDLE;
				end
				else
				begin
					stb_d  = 1'b1;
					code_d = rb_code(idx_q);
					idx_d  = idx_q + 2'h1;
					st_d   = C_WAIT;
				end
			end
			default:
				st_d = C_IDLE;
		endcase
		busy_d = (st_d != C_IDLE);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_q    <= C_IDLE;
			stb_q   <= 1'b0;
			code_q  <= '0;
			ccar_q  <= '0;
			ycar_q  <= '0;
			after_q <= '0;
			quiet_q <= '0;
			idx_q   <= '0;
			acc_q   <= '0;
			done_q  <= 1'b0;
			to_q    <= 1'b0;
			busy_q  <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			stb_q   <= stb_d;
			code_q  <= code_d;
			ccar_q  <= ccar_d;
			ycar_q  <= ycar_d;
			after_q <= after_d;
			quiet_q <= quiet_d;
			idx_q   <= idx_d;
			acc_q   <= acc_d;
			done_q  <= done_d;
			to_q    <= to_d;
			busy_q  <= busy_d;
		end
	end

	assign bus.sel_stb    = stb_q;
	assign bus.sel_code   = code_q;
	assign busy_o         = busy_q;
	assign done_o         = done_q;
	assign timeout_o      = to_q;
	assign clk_carries_o  = ccar_q;
	assign cyc_carries_o  = ycar_q;
	assign counts_o       = acc_q;
endmodule // gfc_controller
`default_nettype wire

// ===== gfc_device.sv
/*
 * counter device end: timebase, gate flip-flop, clock and cycle counters,
 * carry drivers and nibble readback.
 * assumes measured signals and mode levels arrive asynchronously on pins.
 */
`timescale 1ns/1ps
`default_nettype none
module gfc_device (
	// clock and reset
	input  wire logic          ref_clk_i,
	input  wire logic          rst_n_i,
	// instrument bus
	gfc_bus_if.dev             bus,
	// measured signals
	input  wire logic          amp_sig_i,
	input  wire logic          in_sig_i,
	input  wire logic          osc_sig_i,
	// mode and source controls
	input  wire gfc_pkg::gfc_src_t special_function_key_i,
	input  wire logic          volt_mode_i,
	input  wire logic          conv_done_i,
	// status
	output logic               gate_open_o,
	output logic               counting_o
);
	import gfc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int SY_W = 7;
	logic [SY_W-1:0] sy1_q;
	logic [SY_W-1:0] sy2_q;
	logic [SY_W-1:0] sy_raw;

	assign sy_raw = {special_function_key_i, conv_done_i, volt_mode_i,
		osc_sig_i, in_sig_i, amp_sig_i};

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sy1_q <= '0;
			sy2_q <= '0;
		end
		else
		begin
			sy1_q <= sy_raw;
			sy2_q <= sy1_q;
		end
	end

	logic     amp_s;
	logic     in_s;
	logic     osc_s;
	logic     volt_s;
	logic     done_s;
	gfc_src_t src_s;

	assign amp_s  = sy2_q[0];
	assign in_s   = sy2_q[1];
	assign osc_s  = sy2_q[2];
	assign volt_s = sy2_q[3];
	assign done_s = sy2_q[4];
	assign src_s  = gfc_src_t'(sy2_q[6:5]);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic                 selected_measured_signal;
	logic                 selected_measured_signal_prev_q;
	logic                 selected_measured_signal_prev_d;
	logic [TB_W-1:0]      tb_cnt_q;
	logic [TB_W-1:0]      tb_cnt_d;
	logic                 gate_ff_q;	// high holds gate closed
	logic                 gate_ff_d;
	logic                 gate_din_q;
	logic                 gate_din_d;
	logic                 volt_en_q;
	logic                 volt_en_d;
	logic                 drv_en_q;
	logic                 drv_en_d;
	logic [CLK_DIV_W-1:0] clk_cnt_q;
	logic [CLK_DIV_W-1:0] clk_cnt_d;
	logic [CYC_DIV_W-1:0] cyc_cnt_q;
	logic [CYC_DIV_W-1:0] cyc_cnt_d;
	logic                 clk_car_q;
	logic                 clk_car_d;
	logic                 cyc_car_q;
	logic                 cyc_car_d;
	logic [CNT_W-1:0]     rb_q;
	logic [CNT_W-1:0]     rb_d;
	logic                 rb_en_q;
	logic                 rb_en_d;
	logic                 gate_open_q;
	logic                 gate_open_d;
	logic                 counting_q;
	logic                 counting_d;

	function automatic logic is_cmd(input logic stb, input logic [CODE_W-1:0] code,
		input logic [CODE_W-1:0] want);
		is_cmd = stb && (code == want);
	endfunction

	always_comb
	begin
		unique case (src_s)
			GFC_SRC_AMP:   selected_measured_signal = amp_s;
			GFC_SRC_INPUT: selected_measured_signal = in_s;
			GFC_SRC_OSC:   selected_measured_signal = osc_s;
			GFC_SRC_NONE:  selected_measured_signal = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	logic fall;
	logic tb_tick;
	logic freq_gate;
	logic clk_en;

	always_comb
	begin
		fall        = selected_measured_signal_prev_q && !selected_measured_signal;
		tb_tick     = (tb_cnt_q == TB_LAST);
		selected_measured_signal_prev_d = selected_measured_signal;
		tb_cnt_d    = tb_tick ? '0 : tb_cnt_q + 1'b1;
		gate_ff_d   = gate_ff_q;
		gate_din_d  = gate_din_q;
		volt_en_d   = volt_en_q;
		drv_en_d    = drv_en_q;
		clk_cnt_d   = clk_cnt_q;
		cyc_cnt_d   = cyc_cnt_q;
		clk_car_d   = 1'b0;
		cyc_car_d   = 1'b0;
		rb_d        = rb_q;
		rb_en_d     = rb_en_q;

		// frequency gate only when gate flop clear and not in voltage mode
		freq_gate = !gate_ff_q && !volt_s;
		clk_en    = freq_gate || (volt_s && volt_en_q && !done_s);

		// gate flop clocks on falling edge of measured signal
		if (fall)
			gate_ff_d = gate_din_q;

		if (clk_en && tb_tick)
		begin
			clk_cnt_d = clk_cnt_q + 1'b1;
			// no pulse while the line driver is off
			if (&clk_cnt_q && drv_en_q)
				clk_car_d = 1'b1;
		end
		// cycle counter idle in voltage mode
		if (freq_gate && fall)
		begin
			cyc_cnt_d = cyc_cnt_q + 1'b1;
			if (&cyc_cnt_q && drv_en_q)
				cyc_car_d = 1'b1;
		end

		if (is_cmd(bus.sel_stb, bus.sel_code, CMD_ARM))
		begin
			gate_ff_d  = 1'b1;
			gate_din_d = 1'b1;
			volt_en_d  = 1'b0;
			clk_cnt_d  = '0;
			cyc_cnt_d  = '0;
			drv_en_d   = 1'b1;
			rb_en_d    = 1'b0;
			rb_d       = '0;
			clk_car_d  = 1'b0;
			cyc_car_d  = 1'b0;
		end
		else if (is_cmd(bus.sel_stb, bus.sel_code, CMD_OPEN))
		begin
			if (volt_s)
				volt_en_d = 1'b1;
			else
				gate_din_d = 1'b0;
		end
		else if (is_cmd(bus.sel_stb, bus.sel_code, CMD_CLOSE))
			gate_din_d = 1'b1;
		else if (is_cmd(bus.sel_stb, bus.sel_code, CMD_RB_EN))
		begin
			// snapshot of held counts; counters themselves stay put
			rb_d     = {cyc_cnt_q, clk_cnt_q};
			rb_en_d  = 1'b1;
			drv_en_d = 1'b0;
			clk_car_d = 1'b0;
			cyc_car_d = 1'b0;
		end
		else if (rb_en_q && (is_cmd(bus.sel_stb, bus.sel_code, CMD_RB_SH1)
			|| is_cmd(bus.sel_stb, bus.sel_code, CMD_RB_SH2)
			|| is_cmd(bus.sel_stb, bus.sel_code, CMD_RB_SH3)))
			rb_d = {{RB_W{1'b0}}, rb_q[CNT_W-1:RB_W]};

		gate_open_d = freq_gate;
		counting_d  = clk_en;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			selected_measured_signal_prev_q <= 1'b0;
			tb_cnt_q    <= '0;
			gate_ff_q   <= 1'b1;
			gate_din_q  <= 1'b1;
			volt_en_q   <= 1'b0;
			drv_en_q    <= 1'b0;
			clk_cnt_q   <= '0;
			cyc_cnt_q   <= '0;
			clk_car_q   <= 1'b0;
			cyc_car_q   <= 1'b0;
			rb_q        <= '0;
			rb_en_q     <= 1'b0;
			gate_open_q <= 1'b0;
			counting_q  <= 1'b0;
		end
		else
		begin
			selected_measured_signal_prev_q <= selected_measured_signal_prev_d;
			tb_cnt_q    <= tb_cnt_d;
			gate_ff_q   <= gate_ff_d;
			gate_din_q  <= gate_din_d;
			volt_en_q   <= volt_en_d;
			drv_en_q    <= drv_en_d;
			clk_cnt_q   <= clk_cnt_d;
			cyc_cnt_q   <= cyc_cnt_d;
			clk_car_q   <= clk_car_d;
			cyc_car_q   <= cyc_car_d;
			rb_q        <= rb_d;
			rb_en_q     <= rb_en_d;
			gate_open_q <= gate_open_d;
			counting_q  <= counting_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs; carry lines are active low and only driven while armed
	assign bus.clk_carry_n  = !clk_car_q;
	assign bus.clk_carry_oe = drv_en_q;
	assign bus.cyc_carry_n  = !cyc_car_q;
	assign bus.cyc_carry_oe = drv_en_q;
	// rb_q stays zero until readback is enabled, so no output mux
	assign bus.rb_data      = rb_q[RB_W-1:0];
	assign gate_open_o      = gate_open_q;
	assign counting_o       = counting_q;
endmodule // gfc_device
`default_nettype wire

// ===== gfc_pkg.sv
/*
 * constants shared by both ends of the gated frequency counter link.
 * assumes one 40 MHz reference clock feeds both ends.
 */
`default_nettype none
package gfc_pkg;
	// select codes on the instrument bus
	localparam int          CODE_W      = 12;
	localparam logic [11:0] CMD_ARM     = 12'h7f0;
	localparam logic [11:0] CMD_OPEN    = 12'h7e0;
	localparam logic [11:0] CMD_CLOSE   = 12'h7e1;
	localparam logic [11:0] CMD_RB_EN   = 12'h7d0;
	localparam logic [11:0] CMD_RB_SH1  = 12'h7c0;
	localparam logic [11:0] CMD_RB_SH2  = 12'h7b0;
	localparam logic [11:0] CMD_RB_SH3  = 12'h7a0;
	////////////////////////////////////////////////////////////////////////////
	// counter geometry
	localparam int CLK_DIV_W = 11;	// divide by 2048
	localparam int CYC_DIV_W = 5;	// divide by 32
	localparam int RB_W      = 4;	// readback nibble
	localparam int RB_STAGES = 4;
	localparam int CNT_W     = CLK_DIV_W + CYC_DIV_W;
	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int REF_CLK_HZ   = 40_000_000;
	localparam int TIMEBASE_HZ  = 2_000_000;
	localparam int TB_DIV       = REF_CLK_HZ / TIMEBASE_HZ;
	localparam int TB_W         = 5;
	localparam logic [TB_W-1:0] TB_LAST = TB_W'(TB_DIV - 1);
	localparam int CLOSE_TIMEOUT_CARRIES = 16;
	localparam int CARRY_PERIOD_CYC = REF_CLK_HZ / TIMEBASE_HZ * 2048;
	////////////////////////////////////////////////////////////////////////////
	// special function source select (46.x)
	typedef enum logic [1:0] {
		GFC_SRC_OSC   = 2'h0,
		GFC_SRC_INPUT = 2'h1,
		GFC_SRC_NONE  = 2'h2,
		GFC_SRC_AMP   = 2'h3
	} gfc_src_t;
endpackage
`default_nettype wire

// ===== gfc_properties.sv
/*
 * checker for the counter bus link; sees only interface signals.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module gfc_properties (
	// clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_n_i,
	// bus signals
	input  wire logic                        sel_stb,
	input  wire logic [gfc_pkg::CODE_W-1:0]  sel_code,
	input  wire logic [gfc_pkg::RB_W-1:0]    rb_data,
	input  wire logic                        clk_carry_n,
	input  wire logic                        clk_carry_oe,
	input  wire logic                        cyc_carry_n,
	input  wire logic                        cyc_carry_oe
);
	import gfc_pkg::*;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic        arm;
	logic        rben;
	logic [15:0] since_q;
	logic [15:0] since_d;
	logic        rb_q;
	logic        rb_d;
	assign arm  = sel_stb && sel_code == CMD_ARM;
	assign rben = sel_stb && sel_code == CMD_RB_EN;
	////////////////////////////////////////////////////////////////////////////
	// cycles since arm, saturating so an old arm never wraps to look fresh
	always_comb
	begin
		since_d = (since_q == 16'hffff) ? since_q : since_q + 16'h0001;
		rb_d    = rb_q;
		if (arm)
		begin
			since_d = 16'h0000;
			rb_d    = 1'b0;
		end
		else if (rben)
			rb_d = 1'b1;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			since_q <= 16'h0000;
			rb_q    <= 1'b0;
		end
		else
		begin
			since_q <= since_d;
			rb_q    <= rb_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	a_arm_drv_on: assert property (arm |=> clk_carry_oe && cyc_carry_oe)
		else $error("carry drivers not enabled by arm");
	a_drv_paired: assert property (clk_carry_oe == cyc_carry_oe)
		else $error("carry drivers differ");
	a_rben_drv_off: assert property (rben |=> !clk_carry_oe && !cyc_carry_oe)
		else $error("carry drivers still on after readback enable");
	a_clk_pulse_one: assert property ($fell(clk_carry_n) |=> clk_carry_n)
		else $error("clock carry wider than one cycle");
	a_cyc_pulse_one: assert property (!cyc_carry_n |-> cyc_carry_oe ##1 cyc_carry_n)
		else $error("cycle carry bad");
	a_clk_carry_driven: assert property (!clk_carry_n |-> clk_carry_oe)
		else $error("clock carry while driver off");
	// 2048 ticks of 20 clocks after the clear, three ticks of slack
	a_first_carry_late: assert property (!clk_carry_n |-> since_q >= 16'h9fc4)
		else $error("clock carry too soon after arm");
	a_rb_idle_zero: assert property (!rb_q && !$past(rb_q) |-> rb_data == 4'h0)
		else $error("readback data without enable");
	a_rb_moves_on_code: assert property ($changed(rb_data) |-> $past(sel_stb) || $past(sel_stb, 2))
		else $error("readback data moved without a code");
endmodule // gfc_properties
`default_nettype wire
